// *** verilog/sdisps_pkg.sv ***
// constants for the status readback and status pin selector bank
// assumes a 16-bit register word and word-indexed register offsets
package sdisps_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;
	localparam logic [ADDR_W-1:0] OFS_EDH_FLAGS_RECEIVED = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_EDH_FLAGS_OUTGOING = 12'h005;
	localparam logic [ADDR_W-1:0] OFS_STREAM_ONE_FORMAT = 12'h006;
	localparam logic [ADDR_W-1:0] OFS_STREAM_TWO_FORMAT = 12'h007;
	localparam logic [ADDR_W-1:0] OFS_PIN_SELECT_LOW = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_PIN_SELECT_HIGH = 12'h009;

	// ------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------
	localparam int SEL_W = 5;
	localparam int SEL_FIELD0_LSB = 0;
	localparam int SEL_FIELD1_LSB = 5;
	localparam int SEL_FIELD2_LSB = 10;
	localparam int PIN_COUNT = 6;
	localparam int EDH_FLAG_W = 15;
	localparam int STD_W = 6;
	localparam int FMT_W = 4;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [SEL_W-1:0] SEL_RST_PIN0 = 5'h00;
	localparam logic [SEL_W-1:0] SEL_RST_PIN1 = 5'h01;
	localparam logic [SEL_W-1:0] SEL_RST_PIN2 = 5'h02;
	localparam logic [SEL_W-1:0] SEL_RST_PIN3 = 5'h03;
	localparam logic [SEL_W-1:0] SEL_RST_PIN4 = 5'h04;
	localparam logic [SEL_W-1:0] SEL_RST_PIN5 = 5'h06;
	localparam logic [EDH_FLAG_W-1:0] EDH_RX_RST = 15'h0000;
	// unknown-error-status bits 14, 9 and 4 start set
	localparam logic [EDH_FLAG_W-1:0] EDH_TX_RST = 15'h4210;
	localparam logic [STD_W-1:0] STD1_RST = 6'h1d;
	localparam logic [FMT_W-1:0] FMT1_RST = 4'hf;
	localparam logic [STD_W-1:0] STD2_RST = 6'h00;
	localparam logic [FMT_W-1:0] FMT2_RST = 4'h0;

	// ------------------------------------------------------------
	// selector codes
	// ------------------------------------------------------------
	localparam logic [SEL_W-1:0] SRC_HORIZ = 5'h00;
	localparam logic [SEL_W-1:0] SRC_VERT = 5'h01;
	localparam logic [SEL_W-1:0] SRC_FIELD_DE = 5'h02;
	localparam logic [SEL_W-1:0] SRC_LOCKED = 5'h03;
	localparam logic [SEL_W-1:0] SRC_LUMA_ANC = 5'h04;
	localparam logic [SEL_W-1:0] SRC_CHROMA_ANC = 5'h05;
	localparam logic [SEL_W-1:0] SRC_DATA_ERR = 5'h06;
	localparam logic [SEL_W-1:0] SRC_VIDEO_ERR = 5'h07;
	localparam logic [SEL_W-1:0] SRC_EDH_DET = 5'h09;
	localparam logic [SEL_W-1:0] SRC_CARRIER = 5'h0a;
	localparam logic [SEL_W-1:0] SRC_RATE0 = 5'h0b;
	localparam logic [SEL_W-1:0] SRC_RATE1 = 5'h0c;

endpackage

// *** verilog/sdisps_bank.sv ***
// status readback registers and six status pin source selectors
// assumes core-clock-synchronous indicator inputs and a simple word register port
`timescale 1ns/1ps

// Operation
// - code 00000: horizontal blanking, or horizontal sync when timing flag set
// - code 00001: vertical blanking, or vertical sync when timing flag set
// - code 00010: field bit, or data enable when timing flag set
// - code 00011: receiver lock indication
// - code 00100: luma / stream one ancillary presence
// - code 00101: chroma / stream two ancillary presence
// - code 00110 data error, code 00111 video error
// - code 01001: embedded edh packet detected; 01000 has no meaning
// - codes 01010-01100: carrier detect, rate detect bit 0, bit 1
// - codes 01101 and above reserved, no function
// - six 5-bit selectors at 14-10, 9-5, 4-0; bit 15 reserved
// - selectors reset to 0,1,2,3,4,6 for pins 0 to 5
// - received edh flag word read-only, fifteen flags, resets to zero
// - outgoing edh flags read-only; unknown-status flags reset one, rest zero
// - stream one word bits 15,14: full-field, active-picture crc valid, reset zero
// - stream one standard at 13-8, read-only, resets to 29
// - chroma or stream two format at 7-4, resets to 15
// - luma or stream one format at 3-0, resets to 15
// - stream two word: standard 13-8, formats 7-4, 3-0, all reset zero
module sdisps_bank (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [sdisps_pkg::ADDR_W-1:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [sdisps_pkg::DATA_W-1:0] i_reg_wdata,
	output logic [sdisps_pkg::DATA_W-1:0] o_reg_rdata,
	input wire logic i_cea_timing_flag,
	input wire logic i_h_blank,
	input wire logic i_h_sync,
	input wire logic i_v_blank,
	input wire logic i_v_sync,
	input wire logic i_field_bit,
	input wire logic i_data_enable,
	input wire logic i_locked,
	input wire logic i_luma_anc_present,
	input wire logic i_chroma_anc_present,
	input wire logic i_data_error,
	input wire logic i_video_error,
	input wire logic i_edh_detect,
	input wire logic i_carrier_detect,
	input wire logic i_rate_detect_bit0,
	input wire logic i_rate_detect_bit1,
	input wire logic [sdisps_pkg::EDH_FLAG_W-1:0] i_edh_rx_flags,
	input wire logic [sdisps_pkg::EDH_FLAG_W-1:0] i_edh_tx_flags,
	input wire logic i_full_field_crc_valid,
	input wire logic i_active_picture_crc_valid,
	input wire logic [sdisps_pkg::STD_W-1:0] i_stream1_video_standard,
	input wire logic [sdisps_pkg::FMT_W-1:0] i_stream1_chroma_format,
	input wire logic [sdisps_pkg::FMT_W-1:0] i_stream1_luma_format,
	input wire logic [sdisps_pkg::STD_W-1:0] i_stream2_video_standard,
	input wire logic [sdisps_pkg::FMT_W-1:0] i_stream2_chroma_format,
	input wire logic [sdisps_pkg::FMT_W-1:0] i_stream2_luma_format,
	output logic o_status_pin_0,
	output logic o_status_pin_1,
	output logic o_status_pin_2,
	output logic o_status_pin_3,
	output logic o_status_pin_4,
	output logic o_status_pin_5
);
	import sdisps_pkg::*;

	// ------------------------------------------------------------
	// source decode
	// ------------------------------------------------------------
	typedef logic [SEL_W-1:0] sdisps_sel_t;

	// one decoder per pin, called for each of the six pins
	function automatic logic pick_source(input sdisps_sel_t sel, input logic [15:0] src);
		logic r;
		r = 1'b0;
		case (sel)
			SRC_HORIZ: r = src[0];
			SRC_VERT: r = src[1];
			SRC_FIELD_DE: r = src[2];
			SRC_LOCKED: r = src[3];
			SRC_LUMA_ANC: r = src[4];
			SRC_CHROMA_ANC: r = src[5];
			SRC_DATA_ERR: r = src[6];
			SRC_VIDEO_ERR: r = src[7];
			SRC_EDH_DET: r = src[8];
			SRC_CARRIER: r = src[9];
			SRC_RATE0: r = src[10];
			SRC_RATE1: r = src[11];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// timing flag swaps blanking/field for sync/enable
	wire logic src_horiz = i_cea_timing_flag ? i_h_sync : i_h_blank;
	wire logic src_vert = i_cea_timing_flag ? i_v_sync : i_v_blank;
	wire logic src_fde = i_cea_timing_flag ? i_data_enable : i_field_bit;
	wire logic [15:0] src_vec = {4'h0, i_rate_detect_bit1, i_rate_detect_bit0,
		i_carrier_detect, i_edh_detect, i_video_error, i_data_error,
		i_chroma_anc_present, i_luma_anc_present, i_locked, src_fde, src_vert, src_horiz};

	// ------------------------------------------------------------
	// selector registers
	// ------------------------------------------------------------
	wire logic wr_low = i_reg_wr && (i_reg_addr == OFS_PIN_SELECT_LOW);
	wire logic wr_high = i_reg_wr && (i_reg_addr == OFS_PIN_SELECT_HIGH);
	sdisps_sel_t sel_q [PIN_COUNT];
	sdisps_sel_t sel_d [PIN_COUNT];
	logic [PIN_COUNT-1:0] pin_q;
	logic [PIN_COUNT-1:0] pin_d;

	always_comb begin
		sel_d = sel_q;
		if (wr_low) begin
			sel_d[0] = i_reg_wdata[SEL_FIELD0_LSB +: SEL_W];
			sel_d[1] = i_reg_wdata[SEL_FIELD1_LSB +: SEL_W];
			sel_d[2] = i_reg_wdata[SEL_FIELD2_LSB +: SEL_W];
		end else if (wr_high) begin
			sel_d[3] = i_reg_wdata[SEL_FIELD0_LSB +: SEL_W];
			sel_d[4] = i_reg_wdata[SEL_FIELD1_LSB +: SEL_W];
			sel_d[5] = i_reg_wdata[SEL_FIELD2_LSB +: SEL_W];
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sel_q[0] <= SEL_RST_PIN0;
			sel_q[1] <= SEL_RST_PIN1;
			sel_q[2] <= SEL_RST_PIN2;
			sel_q[3] <= SEL_RST_PIN3;
			sel_q[4] <= SEL_RST_PIN4;
			sel_q[5] <= SEL_RST_PIN5;
		end else begin
			sel_q <= sel_d;
		end
	end

	// ------------------------------------------------------------
	// status pins
	// ------------------------------------------------------------
	// pins are registered: glitch-free, one clock behind the selector
	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
			assign pin_d[gi] = pick_source(sel_q[gi], src_vec);
		end
	endgenerate

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pin_q <= '0;
		end else begin
			pin_q <= pin_d;
		end
	end

	assign o_status_pin_0 = pin_q[0];
	assign o_status_pin_1 = pin_q[1];
	assign o_status_pin_2 = pin_q[2];
	assign o_status_pin_3 = pin_q[3];
	assign o_status_pin_4 = pin_q[4];
	assign o_status_pin_5 = pin_q[5];

	// ------------------------------------------------------------
	// read-only status capture
	// ------------------------------------------------------------
	logic [EDH_FLAG_W-1:0] edh_rx_q;
	logic edh_det_q;
	logic [EDH_FLAG_W-1:0] edh_tx_q;
	logic full_field_crc_valid_q;
	logic active_picture_crc_valid_q;
	logic [STD_W-1:0] std1_q;
	logic [FMT_W-1:0] cfmt1_q;
	logic [FMT_W-1:0] yfmt1_q;
	logic [STD_W-1:0] std2_q;
	logic [FMT_W-1:0] cfmt2_q;
	logic [FMT_W-1:0] yfmt2_q;

	// writes to these offsets are ignored
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			edh_rx_q <= EDH_RX_RST;
			edh_det_q <= 1'b0;
			edh_tx_q <= EDH_TX_RST;
			full_field_crc_valid_q <= 1'b0;
			active_picture_crc_valid_q <= 1'b0;
			std1_q <= STD1_RST;
			cfmt1_q <= FMT1_RST;
			yfmt1_q <= FMT1_RST;
			std2_q <= STD2_RST;
			cfmt2_q <= FMT2_RST;
			yfmt2_q <= FMT2_RST;
		end else begin
			edh_rx_q <= i_edh_rx_flags;
			edh_det_q <= i_edh_detect;
			edh_tx_q <= i_edh_tx_flags;
			full_field_crc_valid_q <= i_full_field_crc_valid;
			active_picture_crc_valid_q <= i_active_picture_crc_valid;
			std1_q <= i_stream1_video_standard;
			cfmt1_q <= i_stream1_chroma_format;
			yfmt1_q <= i_stream1_luma_format;
			std2_q <= i_stream2_video_standard;
			cfmt2_q <= i_stream2_chroma_format;
			yfmt2_q <= i_stream2_luma_format;
		end
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	wire logic [DATA_W-1:0] rd_rx = {edh_det_q, edh_rx_q};
	wire logic [DATA_W-1:0] rd_tx = {1'b0, edh_tx_q};
	wire logic [DATA_W-1:0] rd_f1 = {full_field_crc_valid_q, active_picture_crc_valid_q, std1_q, cfmt1_q, yfmt1_q};
	wire logic [DATA_W-1:0] rd_f2 = {2'b00, std2_q, cfmt2_q, yfmt2_q};
	wire logic [DATA_W-1:0] rd_sl = {1'b0, sel_q[2], sel_q[1], sel_q[0]};
	wire logic [DATA_W-1:0] rd_sh = {1'b0, sel_q[5], sel_q[4], sel_q[3]};
	wire logic [DATA_W-1:0] rdata_d =
		(i_reg_addr == OFS_EDH_FLAGS_RECEIVED) ? rd_rx :
		(i_reg_addr == OFS_EDH_FLAGS_OUTGOING) ? rd_tx :
		(i_reg_addr == OFS_STREAM_ONE_FORMAT) ? rd_f1 :
		(i_reg_addr == OFS_STREAM_TWO_FORMAT) ? rd_f2 :
		(i_reg_addr == OFS_PIN_SELECT_LOW) ? rd_sl :
		(i_reg_addr == OFS_PIN_SELECT_HIGH) ? rd_sh : 16'h0000;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_reg_rdata <= 16'h0000;
		end else begin
			o_reg_rdata <= rdata_d;
		end
	end

endmodule

// *** bench/sdisps_pin_host.sv ***
// host-side model: registers the six status pins as external logic would
// assumes pins are synchronous to the core clock
`timescale 1ns/1ps
module sdisps_pin_host (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [5:0] i_status_pins,
	output logic [5:0] o_seen
);
	// one flop only, so a pin glitch between edges goes unseen
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) o_seen <= 6'h00;
		else o_seen <= i_status_pins;
	end
endmodule

// *** bench/sdisps_bank_assertions.sv ***
// checker for pin routing and readback of the status bank
// assumes it is bound onto sdisps_bank and sees its ports only
`timescale 1ns/1ps
module sdisps_chk (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [sdisps_pkg::ADDR_W-1:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [sdisps_pkg::DATA_W-1:0] i_reg_wdata,
	input wire logic [sdisps_pkg::DATA_W-1:0] o_reg_rdata,
	input wire logic i_cea_timing_flag,
	input wire logic i_h_blank,
	input wire logic i_h_sync,
	input wire logic i_data_enable,
	input wire logic i_locked,
	input wire logic i_carrier_detect,
	input wire logic [sdisps_pkg::EDH_FLAG_W-1:0] i_edh_tx_flags,
	input wire logic o_status_pin_0
);
	import sdisps_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// shadow of the low selector word, kept from the write strobe alone
	logic [14:0] lo_q;
	wire [4:0] s0 = lo_q[4:0];
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) lo_q <= 15'h0820;
		else if (i_reg_wr && i_reg_addr == OFS_PIN_SELECT_LOW) lo_q <= i_reg_wdata[14:0];
	end
	property p_hb; (s0 == 5'h00 && !i_cea_timing_flag) |=> o_status_pin_0 == $past(i_h_blank); endproperty
	a_hb: assert property (p_hb) else $error("pin0 not h blank");
	property p_hs; (s0 == 5'h00 && i_cea_timing_flag) |=> o_status_pin_0 == $past(i_h_sync); endproperty
	a_hs: assert property (p_hs) else $error("pin0 not h sync");
	property p_de; (s0 == 5'h02 && i_cea_timing_flag) |=> o_status_pin_0 == $past(i_data_enable); endproperty
	a_de: assert property (p_de) else $error("pin0 not data enable");
	property p_lk; s0 == 5'h03 |=> o_status_pin_0 == $past(i_locked); endproperty
	a_lk: assert property (p_lk) else $error("pin0 not lock");
	property p_cd; s0 == 5'h0a |=> o_status_pin_0 == $past(i_carrier_detect); endproperty
	a_cd: assert property (p_cd) else $error("pin0 not carrier");
	property p_rs; (s0 == 5'h08 || s0 > 5'h0c) |=> !o_status_pin_0; endproperty
	a_rs: assert property (p_rs) else $error("reserved code drives pin0");
	property p_sr; i_reg_addr == OFS_PIN_SELECT_LOW |=> o_reg_rdata == {1'b0, $past(lo_q)}; endproperty
	a_sr: assert property (p_sr) else $error("selector readback wrong");
	property p_tx; (i_reg_addr == OFS_EDH_FLAGS_OUTGOING && $past(i_nrst))
		|=> o_reg_rdata == {1'b0, $past(i_edh_tx_flags, 2)}; endproperty
	a_tx: assert property (p_tx) else $error("outgoing flags readback wrong");
endmodule
bind sdisps_bank sdisps_chk u_chk (.*);

// *** bench/sdisps_bank_tb_top.sv ***
// bench for the status bank: routing table, readback words, mid-run reset
// assumes sdisps_pkg, the bank, checker and pin host compiled before it
`timescale 1ns/1ps
module sdisps_bank_tb_top;
	import sdisps_pkg::*;
	logic i_clk = 0, i_nrst = 0, i_reg_wr = 0, i_cea_timing_flag = 0;
	logic i_full_field_crc_valid = 1, i_active_picture_crc_valid = 0;
	logic [ADDR_W-1:0] i_reg_addr = 12'h000;
	logic [DATA_W-1:0] i_reg_wdata = 16'h0000, o_reg_rdata;
	logic [14:0] src = 15'h0000, i_edh_rx_flags = 15'h1234, i_edh_tx_flags = 15'h5a5a;
	logic [5:0] i_stream1_video_standard = 6'h2a, i_stream2_video_standard = 6'h15, seen;
	logic [3:0] i_stream1_chroma_format = 4'h5, i_stream1_luma_format = 4'h9;
	logic [3:0] i_stream2_chroma_format = 4'hc, i_stream2_luma_format = 4'h3;
	logic o_status_pin_0, o_status_pin_1, o_status_pin_2, o_status_pin_3, o_status_pin_4;
	logic o_status_pin_5;
	wire [5:0] pins = {o_status_pin_5, o_status_pin_4, o_status_pin_3, o_status_pin_2,
		o_status_pin_1, o_status_pin_0};
	int miscompares = 0, comparisons = 0, i;
	// {code, timing flag, source index}; index f means no source
	logic [9:0] rows [18] = '{10'h000, 10'h011, 10'h022, 10'h033, 10'h044, 10'h055, 10'h066,
		10'h087, 10'h0a8, 10'h0c9, 10'h0ea, 10'h12b, 10'h14c, 10'h16d, 10'h18e, 10'h10f,
		10'h1af, 10'h3ef};
	sdisps_bank uut (.*, .i_h_blank(src[0]), .i_h_sync(src[1]), .i_v_blank(src[2]),
		.i_v_sync(src[3]), .i_field_bit(src[4]), .i_data_enable(src[5]), .i_locked(src[6]),
		.i_luma_anc_present(src[7]), .i_chroma_anc_present(src[8]), .i_data_error(src[9]),
		.i_video_error(src[10]), .i_edh_detect(src[11]), .i_carrier_detect(src[12]),
		.i_rate_detect_bit0(src[13]), .i_rate_detect_bit1(src[14]));
	sdisps_pin_host u_host (.i_clk(i_clk), .i_nrst(i_nrst), .i_status_pins(pins), .o_seen(seen));
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1;
		@(negedge i_clk);
		i_reg_wr = 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		i_reg_addr = a;
		@(negedge i_clk);
		chk("rdata", e, o_reg_rdata);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		#20000;
		miscompares++;
		wrap_up();
	end
	initial begin
		repeat (16) @(negedge i_clk);
		i_nrst = 1;
		for (i = 0; i < 18; i++) begin
			wr(OFS_PIN_SELECT_LOW, {6'h02, 5'h01, rows[i][9:5]});
			i_cea_timing_flag = rows[i][4];
			src = rows[i][3:0] == 4'hf ? 15'h7fff : 15'h0001 << rows[i][3:0];
			@(negedge i_clk);
			chk("pin0", {15'h0000, rows[i][3:0] != 4'hf}, {15'h0000, o_status_pin_0});
			src = ~src;
			@(negedge i_clk);
			chk("pin0 low", 16'h0000, {15'h0000, o_status_pin_0});
		end
		rd(OFS_PIN_SELECT_LOW, 16'h083f);
		wr(OFS_PIN_SELECT_HIGH, 16'h8c4a);
		i_cea_timing_flag = 0;
		src = 15'h0040;
		@(negedge i_clk);
		chk("pins 5..3", 16'h0004, {13'h0000, pins[5:3]});
		@(negedge i_clk);
		chk("host seen 5..3", 16'h0004, {13'h0000, seen[5:3]});
		rd(OFS_PIN_SELECT_HIGH, 16'h0c4a);
		wr(OFS_STREAM_ONE_FORMAT, 16'h0000);
		rd(OFS_STREAM_ONE_FORMAT, 16'haa59);
		rd(OFS_EDH_FLAGS_RECEIVED, 16'h1234);
		rd(OFS_EDH_FLAGS_OUTGOING, 16'h5a5a);
		rd(OFS_STREAM_TWO_FORMAT, 16'h15c3);
		rd(12'h0ff, 16'h0000);
		i_nrst = 0;
		i_reg_addr = OFS_EDH_FLAGS_OUTGOING;
		@(negedge i_clk);
		chk("pins in reset", 16'h0000, {10'h000, pins});
		i_nrst = 1;
		@(negedge i_clk);
		chk("outgoing reset", 16'h4210, o_reg_rdata);
		rd(OFS_PIN_SELECT_LOW, 16'h0820);
		rd(OFS_PIN_SELECT_HIGH, 16'h1883);
		wrap_up();
	end
endmodule
